// *** rtl/dus_pkg.sv ***
/*
  Package for the update-transfer and amplitude-shaping block: register offsets,
  control bit positions, reset values, timing counts and shared structs.
  Assumes a synchronous register write port in the surrounding device.
*/
package dus_pkg;
  // register offsets (byte addresses of the programming bus)
  localparam logic [5:0] ADDR_UPDATE_PERIOD = 6'h16;
  localparam logic [5:0] ADDR_POWER_DOWN = 6'h1d;
  localparam logic [5:0] ADDR_UPDATE_MODE = 6'h1f;
  localparam logic [5:0] ADDR_OUTPUT_PATH = 6'h20;
  localparam logic [5:0] ADDR_AMPLITUDE = 6'h21;
  localparam logic [5:0] ADDR_AUX_WORD = 6'h26;
  // bit positions
  localparam int BIT_BOTH_PD = 4;
  localparam int BIT_AUX_PD = 2;
  localparam int BIT_INT_UPDATE = 0;
  localparam int BIT_SINC_BYPASS = 6;
  localparam int BIT_MULT_ENABLE = 5;
  localparam int BIT_RAMP_SELECT = 4;
  // reset values
  localparam logic [7:0] RST_POWER_DOWN = 8'h00;
  localparam logic [7:0] RST_UPDATE_MODE = 8'h01;
  localparam logic [7:0] RST_OUTPUT_PATH = 8'h20;
  localparam logic [31:0] RST_UPDATE_PERIOD = 32'h0000_0001;
  localparam logic [7:0] RST_RAMP_RATE = 8'h01;
  // timing and amplitude limits
  localparam logic [3:0] UPDATE_PULSE_CYCLES = 4'ha;
  localparam logic [11:0] AMP_FULL = 12'hfff;
  localparam logic [11:0] AMP_ZERO = 12'h000;

  typedef struct packed {
    logic both_pd;
    logic aux_pd;
    logic int_update;
    logic sinc_bypass;
    logic mult_enable;
    logic ramp_select;
  } dus_ctrl_s;

  typedef struct packed {
    logic [31:0] period;
    logic [11:0] amplitude;
    logic [11:0] aux_word;
    logic [7:0] ramp_rate;
  } dus_words_s;
endpackage

// *** rtl/dus_sync.sv ***
/*
  Two-stage synchroniser for an asynchronous pin, with rising-edge detector.
  Assumes one system clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module dus_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level_out = sync;
  assign rise_out = sync & ~prev;
endmodule

// *** rtl/dus_top.sv ***
/*
  Update transfer and amplitude shaping of a synthesiser: buffer-to-core transfer
  on update edges from pin or internal counter, ramped keying, multiplier,
  inverse-sinc bypass, auxiliary word and power-down.
  Assumes a synchronous register write/read port and the sine samples arriving
  on the system clock. The sinc filter itself lies outside; this block only steers.
*/
// Overview of operation
// (R01) settings other than the internal-update bit reach the core only on an update rising edge, pin or counter
// (R02) external update edge is synchronised to the system clock first
// (R03) internal-update bit resets high; low selects external update edges
// (R04) internal mode: 32-bit down-counter at half rate, update at zero
// (R05) update interval is (N+1) half-rate ticks; host keeps N nonzero
// (R06) internal update drives the pin high for exactly ten cycles
// (R07) multiplier enable low bypasses multiplier, full-scale output
// (R08) ramp select high uses ramp counter, low uses amplitude word
// (R09) 8-bit ramp-rate down-counter reloads, pulses at zero
// (R10) each step moves the 12-bit amplitude counter one LSB
// (R11) zero coefficient gives zero, all ones gives unity gain
// (R12) step pulses every N+1 cycles: load edge then decrements
// (R13) full ramp takes 4095 steps
// (R14) keying high ramps up and holds, low ramps down to zero
// (R15) inverse sinc on by default, bypass bit removes it
// (R16) multiplier sits after the sinc filter, before the sine converter
// (R17) shared power-down bit powers down both converters
// (R18) auxiliary output changes only on an update pulse
// (R19) auxiliary power-down bit powers down only the auxiliary converter
// (R20) auxiliary data goes to the converter unfiltered
// (R21) update pin direction follows the internal-update bit
// (R22) keying pin acts only when selected, never on auxiliary converter
// (R23) pin passes two flops and edge detect to a one-cycle transfer strobe
`timescale 1ns/1ns
module dus_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [5:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [5:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  input wire logic [7:0] ramp_rate_in,
  input wire logic update_strobe_pin_in,
  output logic update_strobe_pin_out,
  output logic update_strobe_pin_oe_out,
  input wire logic keying_pin_in,
  input wire logic [11:0] sine_raw_in,
  input wire logic [11:0] sine_filtered_in,
  output logic [11:0] sine_dac_out,
  output logic [11:0] aux_dac_out,
  output logic sine_pd_out,
  output logic aux_pd_out,
  output logic transfer_out
);
  // buffer (programmed) and active (core) copies
  dus_pkg::dus_ctrl_s buf_ctrl;
  dus_pkg::dus_ctrl_s act_ctrl;
  dus_pkg::dus_words_s buf_words;
  dus_pkg::dus_words_s act_words;
  dus_pkg::dus_ctrl_s next_buf_ctrl;
  dus_pkg::dus_ctrl_s next_act_ctrl;
  dus_pkg::dus_words_s next_buf_words;
  dus_pkg::dus_words_s next_act_words;
  logic [7:0] next_rd_data;

  // update machinery
  logic half_tick;
  logic [31:0] upd_count;
  logic [3:0] pulse_count;
  logic next_half_tick;
  logic [31:0] next_upd_count;
  logic [3:0] next_pulse_count;
  logic int_update;
  logic ext_rise;
  logic transfer;
  logic next_pin_out;
  logic next_pin_oe;

  // amplitude shaping
  logic [7:0] ramp_count;
  logic [11:0] amp_count;
  logic step;
  logic [7:0] next_ramp_count;
  logic [11:0] next_amp_count;
  logic key_sync;
  logic key_meta;
  logic next_key_meta;
  logic next_key_sync;
  logic [11:0] coeff;
  logic [11:0] sine_sel;
  logic [23:0] product;
  logic [11:0] next_sine;
  logic [11:0] next_aux;

  // control reset image taken from the register reset bytes
  localparam dus_pkg::dus_ctrl_s RST_CTRL = '{
    dus_pkg::RST_POWER_DOWN[dus_pkg::BIT_BOTH_PD],
    dus_pkg::RST_POWER_DOWN[dus_pkg::BIT_AUX_PD],
    dus_pkg::RST_UPDATE_MODE[dus_pkg::BIT_INT_UPDATE],
    dus_pkg::RST_OUTPUT_PATH[dus_pkg::BIT_SINC_BYPASS],
    dus_pkg::RST_OUTPUT_PATH[dus_pkg::BIT_MULT_ENABLE],
    dus_pkg::RST_OUTPUT_PATH[dus_pkg::BIT_RAMP_SELECT]
  };

  dus_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(update_strobe_pin_in),
    .level_out(),
    .rise_out(ext_rise)
  );

  // register writes into buffer copy
  always_comb
  begin
    next_buf_ctrl = buf_ctrl;
    next_buf_words = buf_words;
    next_buf_words.ramp_rate = ramp_rate_in;
    if (wr_en_in)
    begin
      if (wr_addr_in >= dus_pkg::ADDR_UPDATE_PERIOD
          && wr_addr_in <= dus_pkg::ADDR_UPDATE_PERIOD + 6'h03)
      begin
        case (2'(wr_addr_in - dus_pkg::ADDR_UPDATE_PERIOD))
          2'h0: next_buf_words.period[31:24] = wr_data_in;
          2'h1: next_buf_words.period[23:16] = wr_data_in;
          2'h2: next_buf_words.period[15:8] = wr_data_in;
          default: next_buf_words.period[7:0] = wr_data_in;
        endcase
      end
      else if (wr_addr_in == dus_pkg::ADDR_POWER_DOWN)
      begin
        next_buf_ctrl.both_pd = wr_data_in[dus_pkg::BIT_BOTH_PD];
        next_buf_ctrl.aux_pd = wr_data_in[dus_pkg::BIT_AUX_PD];
      end
      else if (wr_addr_in == dus_pkg::ADDR_UPDATE_MODE)
      begin
        next_buf_ctrl.int_update = wr_data_in[dus_pkg::BIT_INT_UPDATE];
      end
      else if (wr_addr_in == dus_pkg::ADDR_OUTPUT_PATH)
      begin
        next_buf_ctrl.sinc_bypass = wr_data_in[dus_pkg::BIT_SINC_BYPASS];
        next_buf_ctrl.mult_enable = wr_data_in[dus_pkg::BIT_MULT_ENABLE];
        next_buf_ctrl.ramp_select = wr_data_in[dus_pkg::BIT_RAMP_SELECT];
      end
      else if (wr_addr_in == dus_pkg::ADDR_AMPLITUDE)
      begin
        next_buf_words.amplitude[11:8] = wr_data_in[3:0];
      end
      else if (wr_addr_in == dus_pkg::ADDR_AMPLITUDE + 6'h01)
      begin
        next_buf_words.amplitude[7:0] = wr_data_in;
      end
      else if (wr_addr_in == dus_pkg::ADDR_AUX_WORD)
      begin
        next_buf_words.aux_word[11:8] = wr_data_in[3:0];
      end
      else if (wr_addr_in == dus_pkg::ADDR_AUX_WORD + 6'h01)
      begin
        next_buf_words.aux_word[7:0] = wr_data_in;
      end
    end
  end

  // readback of the buffer copy; unmapped reads as zero
  always_comb
  begin
    next_rd_data = 8'h00;
    if (rd_addr_in == dus_pkg::ADDR_UPDATE_PERIOD)
      next_rd_data = buf_words.period[31:24];
    else if (rd_addr_in == dus_pkg::ADDR_UPDATE_PERIOD + 6'h01)
      next_rd_data = buf_words.period[23:16];
    else if (rd_addr_in == dus_pkg::ADDR_UPDATE_PERIOD + 6'h02)
      next_rd_data = buf_words.period[15:8];
    else if (rd_addr_in == dus_pkg::ADDR_UPDATE_PERIOD + 6'h03)
      next_rd_data = buf_words.period[7:0];
    else if (rd_addr_in == dus_pkg::ADDR_POWER_DOWN)
    begin
      next_rd_data[dus_pkg::BIT_BOTH_PD] = buf_ctrl.both_pd;
      next_rd_data[dus_pkg::BIT_AUX_PD] = buf_ctrl.aux_pd;
    end
    else if (rd_addr_in == dus_pkg::ADDR_UPDATE_MODE)
      next_rd_data[dus_pkg::BIT_INT_UPDATE] = buf_ctrl.int_update;
    else if (rd_addr_in == dus_pkg::ADDR_OUTPUT_PATH)
    begin
      next_rd_data[dus_pkg::BIT_SINC_BYPASS] = buf_ctrl.sinc_bypass;
      next_rd_data[dus_pkg::BIT_MULT_ENABLE] = buf_ctrl.mult_enable;
      next_rd_data[dus_pkg::BIT_RAMP_SELECT] = buf_ctrl.ramp_select;
    end
    else if (rd_addr_in == dus_pkg::ADDR_AMPLITUDE)
      next_rd_data = {4'h0, buf_words.amplitude[11:8]};
    else if (rd_addr_in == dus_pkg::ADDR_AMPLITUDE + 6'h01)
      next_rd_data = buf_words.amplitude[7:0];
    else if (rd_addr_in == dus_pkg::ADDR_AUX_WORD)
      next_rd_data = {4'h0, buf_words.aux_word[11:8]};
    else if (rd_addr_in == dus_pkg::ADDR_AUX_WORD + 6'h01)
      next_rd_data = buf_words.aux_word[7:0];
  end

  // internal update counter at half rate and pin pulse
  assign int_update = act_ctrl.int_update & half_tick && upd_count == 32'h0000_0000; // R04
  // external edge only counts in external mode
  assign transfer = int_update | (~act_ctrl.int_update & ext_rise); // R01 R02 R23

  always_comb
  begin
    next_half_tick = ~half_tick;
    next_upd_count = upd_count;
    if (act_ctrl.int_update && half_tick)
    begin
      if (upd_count == 32'h0000_0000)
        next_upd_count = buf_words.period; // R05
      else
        next_upd_count = upd_count - 32'h0000_0001; // R04
    end
    next_pulse_count = pulse_count;
    if (int_update)
      next_pulse_count = dus_pkg::UPDATE_PULSE_CYCLES; // R06
    else if (pulse_count != 4'h0)
      next_pulse_count = pulse_count - 4'h1;
    next_pin_out = int_update || (pulse_count > 4'h1); // R06
    next_pin_oe = act_ctrl.int_update; // R21
  end

  // core transfer: active copy follows buffer only on transfer, except the mode bit
  always_comb
  begin
    next_act_ctrl = act_ctrl;
    next_act_words = act_words;
    if (transfer)
    begin
      next_act_ctrl = buf_ctrl; // R01
      next_act_words = buf_words;
    end
    // mode bit itself steers the update source at once
    next_act_ctrl.int_update = buf_ctrl.int_update; // R03
  end

  // ramp-rate counter and amplitude counter
  assign step = ramp_count == 8'h00; // R09
  always_comb
  begin
    next_key_meta = keying_pin_in;
    next_key_sync = key_meta;
    next_ramp_count = step ? act_words.ramp_rate : ramp_count - 8'h01; // R12
    next_amp_count = amp_count;
    if (step && act_ctrl.mult_enable && act_ctrl.ramp_select) // R22
    begin
      if (key_sync && amp_count != dus_pkg::AMP_FULL) // R14
        next_amp_count = amp_count + 12'h001; // R10 R13
      else if (!key_sync && amp_count != dus_pkg::AMP_ZERO)
        next_amp_count = amp_count - 12'h001; // R14
    end
  end

  // sample path: sinc choice, then multiplier
  always_comb
  begin
    sine_sel = act_ctrl.sinc_bypass ? sine_raw_in : sine_filtered_in; // R15
    coeff = act_ctrl.ramp_select ? amp_count : act_words.amplitude; // R08
    // all-ones coefficient is unity, not 4095/4096
    if (coeff == dus_pkg::AMP_FULL)
      product = {sine_sel, 12'h000}; // R11
    else
      product = sine_sel * coeff; // R11
    next_sine = act_ctrl.mult_enable ? product[23:12] : sine_sel; // R07 R16
    next_aux = transfer ? buf_words.aux_word : aux_dac_out; // R18 R20
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      buf_ctrl <= RST_CTRL; // R03
      act_ctrl <= RST_CTRL;
      buf_words <= '{dus_pkg::RST_UPDATE_PERIOD, 12'h000, 12'h000, dus_pkg::RST_RAMP_RATE};
      act_words <= '{dus_pkg::RST_UPDATE_PERIOD, 12'h000, 12'h000, dus_pkg::RST_RAMP_RATE};
      half_tick <= 1'b0;
      upd_count <= dus_pkg::RST_UPDATE_PERIOD;
      pulse_count <= 4'h0;
      update_strobe_pin_out <= 1'b0;
      update_strobe_pin_oe_out <= 1'b1;
      ramp_count <= 8'h00;
      amp_count <= 12'h000;
      key_meta <= 1'b0;
      key_sync <= 1'b0;
      sine_dac_out <= 12'h000;
      aux_dac_out <= 12'h000;
      sine_pd_out <= 1'b0;
      aux_pd_out <= 1'b0;
      transfer_out <= 1'b0;
      rd_data_out <= 8'h00;
    end
    else
    begin
      buf_ctrl <= next_buf_ctrl;
      act_ctrl <= next_act_ctrl;
      buf_words <= next_buf_words;
      act_words <= next_act_words;
      half_tick <= next_half_tick;
      upd_count <= next_upd_count;
      pulse_count <= next_pulse_count;
      update_strobe_pin_out <= next_pin_out;
      update_strobe_pin_oe_out <= next_pin_oe;
      ramp_count <= next_ramp_count;
      amp_count <= next_amp_count;
      key_meta <= next_key_meta;
      key_sync <= next_key_sync;
      sine_dac_out <= next_sine;
      aux_dac_out <= next_aux;
      sine_pd_out <= act_ctrl.both_pd; // R17
      aux_pd_out <= act_ctrl.both_pd | act_ctrl.aux_pd; // R17 R19
      transfer_out <= transfer;
      rd_data_out <= next_rd_data;
    end
  end
endmodule

// *** dv/dus_top_asserts.sv ***
/*
  Checker for dus_top port timing: update pulse, transfers, power-down.
  Assumes it is bound to dus_top on the single system clock.
*/
`timescale 1ns/1ns
module dus_top_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic update_strobe_pin_in,
  input wire logic update_strobe_pin_out,
  input wire logic update_strobe_pin_oe_out,
  input wire logic [11:0] aux_dac_out,
  input wire logic sine_pd_out,
  input wire logic aux_pd_out,
  input wire logic transfer_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_pulse;
    $rose(update_strobe_pin_out) |-> update_strobe_pin_out[*8] ##1 update_strobe_pin_out[*2];
  endproperty
  a_pulse: assert property (p_pulse) else $error("update pulse too short");
  property p_width;
    $fell(update_strobe_pin_out) |-> $past(transfer_out, 10);
  endproperty
  a_width: assert property (p_width) else $error("update pulse too long");
  property p_drive;
    $rose(update_strobe_pin_out) |-> update_strobe_pin_oe_out;
  endproperty
  a_drive: assert property (p_drive) else $error("pulse while pin released");
  property p_space;
    transfer_out |=> (!transfer_out)[*3];
  endproperty
  a_space: assert property (p_space) else $error("transfers too close");
  property p_aux;
    $changed(aux_dac_out) |-> transfer_out;
  endproperty
  a_aux: assert property (p_aux) else $error("aux changed without transfer");
  property p_pd;
    sine_pd_out |-> aux_pd_out;
  endproperty
  a_pd: assert property (p_pd) else $error("shared power-down missed aux");
  property p_sync;
    $rose(update_strobe_pin_in) && !update_strobe_pin_oe_out |-> ##[2:5] transfer_out;
  endproperty
  a_sync: assert property (p_sync) else $error("pin edge gave no transfer");
  property p_mode;
    $fell(rst_in) |-> update_strobe_pin_oe_out;
  endproperty
  a_mode: assert property (p_mode) else $error("not internal mode after reset");
  property p_pdchg;
    $changed(sine_pd_out) |-> $past(transfer_out);
  endproperty
  a_pdchg: assert property (p_pdchg) else $error("power-down changed early");
endmodule

// *** dv/dus_host.sv ***
/*
  Host model: supplies update edges and the keying level.
  Assumes its strobe reaches the pin only while the device releases it.
*/
`timescale 1ns/1ns
module dus_host (
  input wire logic clk_in,
  output logic strobe_out,
  output logic key_out
);
  initial
  begin
    strobe_out = 1'b0;
    key_out = 1'b0;
  end
  task automatic strobe();
    @(negedge clk_in);
    strobe_out = 1'b1;
    repeat (4) @(negedge clk_in);
    strobe_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic key(input logic lvl);
    @(negedge clk_in);
    key_out = lvl;
  endtask
endmodule

// *** dv/dus_top_tb_top.sv ***
/*
  Testbench for dus_top: registers, update modes, output path, keying ramp.
  Assumes dus_host as far side and the checker bound below.
*/
`timescale 1ns/1ns
module dus_top_tb_top;
  logic clk_in, rst_in, wr_en, pin_out, pin_oe, sine_pd, aux_pd, xfer, key, strobe;
  logic [5:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, ramp;
  logic [11:0] raw, filt, sine, aux;
  wire logic pin_w;
  int errors = 0;
  int cmp_count = 0;
  assign pin_w = pin_oe ? pin_out : strobe;
  dus_top dus_top_i (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en), .wr_addr_in(wr_addr),
    .wr_data_in(wr_data), .rd_addr_in(rd_addr), .rd_data_out(rd_data), .ramp_rate_in(ramp),
    .update_strobe_pin_in(pin_w), .update_strobe_pin_out(pin_out),
    .update_strobe_pin_oe_out(pin_oe), .keying_pin_in(key), .sine_raw_in(raw),
    .sine_filtered_in(filt), .sine_dac_out(sine), .aux_dac_out(aux), .sine_pd_out(sine_pd),
    .aux_pd_out(aux_pd), .transfer_out(xfer));
  dus_host dus_host_i (.clk_in(clk_in), .strobe_out(strobe), .key_out(key));
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(inout int n);
    @(negedge clk_in);
    n++;
    if (n > 20000)
    begin
      errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk_in);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    rd_addr = a;
    @(negedge clk_in);
    check("rd_data", {24'h0, rd_data}, {24'h0, exp});
  endtask
  task automatic wait_xfer(output int n);
    n = 0;
    do
      tick(n);
    while (xfer !== 1'b1);
  endtask
  task automatic upd(output int n);
    fork
      dus_host_i.strobe();
      wait_xfer(n);
    join
  endtask
  task automatic t_reset();
    check("oe", {31'h0, pin_oe}, 32'h1);
    rd(dus_pkg::ADDR_UPDATE_MODE, dus_pkg::RST_UPDATE_MODE);
    rd(dus_pkg::ADDR_OUTPUT_PATH, dus_pkg::RST_OUTPUT_PATH);
    rd(dus_pkg::ADDR_POWER_DOWN, dus_pkg::RST_POWER_DOWN);
    rd(6'h3f, 8'h00);
    check("sine", {20'h0, sine}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_internal();
    int n;
    int k;
    wr(6'h16, 8'h00);
    wr(6'h17, 8'h00);
    wr(6'h18, 8'h00);
    wr(6'h19, 8'h14);
    wr(dus_pkg::ADDR_AUX_WORD, 8'h0a);
    wr(6'h27, 8'hbc);
    wr(dus_pkg::ADDR_POWER_DOWN, 8'h01 << dus_pkg::BIT_AUX_PD);
    repeat (3) wait_xfer(n);
    check("aux", {20'h0, aux}, 32'habc);
    check("pd", {30'h0, sine_pd, aux_pd}, 32'h1);
    k = 0;
    for (int i = 0; i < 3 && pin_out !== 1'b1; i++) @(negedge clk_in);
    while (pin_out === 1'b1 && k < 20) tick(k);
    check("pulse", k, 10);
    wait_xfer(n);
    wait_xfer(n);
    check("period", n, 42);
    wr(dus_pkg::ADDR_POWER_DOWN, 8'h01 << dus_pkg::BIT_BOTH_PD);
    wait_xfer(n);
    @(negedge clk_in);
    check("pd", {30'h0, sine_pd, aux_pd}, 32'h3);
    $display("test internal done");
  endtask
  task automatic t_external();
    int n;
    wr(dus_pkg::ADDR_UPDATE_MODE, 8'h00);
    wr(dus_pkg::ADDR_POWER_DOWN, 8'h00);
    wr(dus_pkg::ADDR_AUX_WORD, 8'h03);
    wr(6'h27, 8'h21);
    check("oe", {31'h0, pin_oe}, 32'h0);
    repeat (30) @(negedge clk_in);
    check("aux", {20'h0, aux}, 32'habc);
    upd(n);
    check("aux", {20'h0, aux}, 32'h321);
    check("pd", {30'h0, sine_pd, aux_pd}, 32'h0);
    check("sync", {31'h0, n inside {[4:6]}}, 32'h1);
    $display("test external done");
  endtask
  task automatic t_path();
    logic [7:0] pth [6] = '{8'h00, 8'h40, 8'h20, 8'h20, 8'h20, 8'h60};
    logic [11:0] amw [6] = '{12'h000, 12'h000, 12'hfff, 12'h000, 12'h800, 12'h800};
    logic [11:0] exv [6] = '{12'h9ab, 12'h456, 12'h9ab, 12'h000, 12'h4d5, 12'h22b};
    int n;
    filt = 12'h9ab;
    raw = 12'h456;
    for (int i = 0; i < 6; i++)
    begin
      wr(dus_pkg::ADDR_OUTPUT_PATH, pth[i]);
      wr(dus_pkg::ADDR_AMPLITUDE, {4'h0, amw[i][11:8]});
      wr(6'h22, amw[i][7:0]);
      upd(n);
      repeat (2) @(negedge clk_in);
      check("sine", {20'h0, sine}, {20'h0, exv[i]});
    end
    $display("test path done");
  endtask
  task automatic t_ramp();
    int n;
    logic [11:0] s;
    filt = 12'hfff;
    wr(dus_pkg::ADDR_OUTPUT_PATH, 8'h30);
    upd(n);
    repeat (2) @(negedge clk_in);
    check("sine", {20'h0, sine}, 32'h0);
    dus_host_i.key(1'b1);
    n = 0;
    while (sine !== 12'hfff) tick(n);
    check("ramp up", {31'h0, n inside {[8185:8200]}}, 32'h1);
    dus_host_i.key(1'b0);
    n = 0;
    while (sine !== 12'h000) tick(n);
    check("ramp down", {31'h0, n inside {[8185:8200]}}, 32'h1);
    ramp = 8'h03;
    upd(n);
    dus_host_i.key(1'b1);
    for (int j = 0; j < 2; j++)
    begin
      s = sine;
      n = 0;
      while (sine === s && n < 40) tick(n);
    end
    check("step", n, 32'h4);
    $display("test ramp done");
  endtask
  initial
  begin
    rst_in = 1'b1;
    wr_en = 1'b0;
    wr_addr = 6'h00;
    wr_data = 8'h00;
    rd_addr = 6'h00;
    ramp = 8'h01;
    raw = 12'h000;
    filt = 12'h9ab;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_internal();
    t_external();
    t_path();
    t_ramp();
    complete_run();
  end
endmodule
bind dus_top dus_top_asserts dus_top_asserts_i (.clk_in(clk_in), .rst_in(rst_in),
  .update_strobe_pin_in(update_strobe_pin_in), .update_strobe_pin_out(update_strobe_pin_out),
  .update_strobe_pin_oe_out(update_strobe_pin_oe_out), .aux_dac_out(aux_dac_out),
  .sine_pd_out(sine_pd_out), .aux_pd_out(aux_pd_out), .transfer_out(transfer_out));
